// >>> adcrd_pkg.sv
// constants for the converter result and identification readout
`default_nettype none
package adcrd_pkg;
    // command codes of the readable words
    localparam logic [7:0] CMD_BAT_CURRENT = 8'h24;
    localparam logic [7:0] CMD_INPUT_CURRENT = 8'h25;
    localparam logic [7:0] CMD_RAIL_VOLTAGE = 8'h26;
    localparam logic [7:0] CMD_MAKER_CODE = 8'hfe;
    localparam logic [7:0] CMD_PART_CODE = 8'hff;
    // field positions
    localparam int CHG_LSB = 8;
    localparam int CHG_W = 7;
    localparam int DCHG_LSB = 0;
    localparam int DCHG_W = 7;
    localparam int HI_LSB = 8;
    localparam int LO_LSB = 0;
    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;
    // reset value of the result words and the value read at unmapped commands
    localparam logic [15:0] RESULT_RST = 16'h0000;
    localparam logic [15:0] UNMAPPED_VAL = 16'h0000;
    // bit counter values of the serial engine
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] BIT_FIRST = 4'h1;
    localparam logic [3:0] BIT_NONE = 4'h0;
    // engine states, gray along the write path
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_ADDR = 4'b0001,
        ST_ADDR_ACK = 4'b0011,
        ST_CMD = 4'b0010,
        ST_CMD_ACK = 4'b0110,
        ST_WDATA = 4'b0111,
        ST_WACK = 4'b0101,
        ST_RDATA = 4'b0100,
        ST_RACK = 4'b1100
    } adcrd_state_t;
endpackage : adcrd_pkg
`default_nettype wire

// >>> adcrd_sync.sv
// two flip-flop synchroniser for one pin input
`default_nettype none
module adcrd_sync #(
    parameter logic RST_VAL = 1'b1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // pin side and synchronised side
    input wire logic pin_in,
    output var logic sync_out
);
    logic meta_r;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_r <= pin_in;
            sync_out <= meta_r;
        end
    end
endmodule : adcrd_sync
`default_nettype wire

// >>> adcrd_readout.sv
// smbus readout of converter results and identification words
// Functional notes
// - charge current, 7 bits at 14..8, 64 mA per count, 8.128 A full scale.
// - discharge current, 7 bits at 6..0, 256 mA per count, 32.512 A.
// - bits 15 and 7 of battery-current word unused; host ignores them.
// - input current in upper byte, 50 mA per count, 12.75 A full scale.
// - comparator pin level in lower byte, 12 mV per count, 3.06 V.
// - system rail in upper byte, 64 mV per count, from 2.88 V.
// - battery voltage in lower byte, 64 mV per count, 2.88 to 19.2 V.
// - result words at commands 24h, 25h, 26h, all read-only.
// - fixed 16-bit maker code returned at command FEh.
// - command FFh returns part code low byte, high byte zero.
`default_nettype none
module adcrd_readout
    import adcrd_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = 7'h09,
    parameter logic [15:0] MAKER_CODE = 16'h5a3c, // arbitrary value
    parameter logic [7:0] PART_CODE = 8'ha5 // arbitrary value
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // smbus pins, open drain
    input wire logic scl_in,
    input wire logic sda_in,
    output var logic sda_out,
    output var logic sda_oe,
    // converter results, one round per conv_done pulse
    input wire logic conv_done,
    input wire logic [6:0] charge_current_reading,
    input wire logic [6:0] discharge_current_reading,
    input wire logic [7:0] input_current_reading,
    input wire logic [7:0] comparator_pin_level,
    input wire logic [7:0] system_rail_reading,
    input wire logic [7:0] battery_voltage_reading
);
    logic scl_s;
    logic sda_s;
    logic scl_d_r;
    logic sda_d_r;
    logic [15:0] battery_current_result_r;
    logic [15:0] input_current_cmp_result_r;
    logic [15:0] rail_voltage_result_r;
    logic [15:0] rd_word;
    adcrd_state_t state_r;
    logic [3:0] bitcnt_r;
    logic [7:0] shift_r;
    logic [7:0] cmd_r;
    logic [15:0] tx_r;
    logic rw_r;
    logic byte_hi_r;
    logic ack_ok_r;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers and bus event detection
    adcrd_sync #(.RST_VAL(1'b1)) u_scl_sync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .pin_in(scl_in),
        .sync_out(scl_s)
    );
    adcrd_sync #(.RST_VAL(1'b1)) u_sda_sync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .pin_in(sda_in),
        .sync_out(sda_s)
    );

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    assign scl_rise = scl_s && !scl_d_r;
    assign scl_fall = !scl_s && scl_d_r;
    assign start_cond = scl_s && scl_d_r && !sda_s && sda_d_r;
    assign stop_cond = scl_s && scl_d_r && sda_s && !sda_d_r;

    ////////////////////////////////////////////////////////////////////////
    // result words: all fields of one round latched on one edge
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            battery_current_result_r <= RESULT_RST;
            input_current_cmp_result_r <= RESULT_RST;
            rail_voltage_result_r <= RESULT_RST;
        end else if (conv_done) begin
            // unused bits 15 and 7 read as zero
            battery_current_result_r <= {1'b0, charge_current_reading,
                1'b0, discharge_current_reading};
            input_current_cmp_result_r <= {input_current_reading,
                comparator_pin_level};
            rail_voltage_result_r <= {system_rail_reading,
                battery_voltage_reading};
        end
    end

    // read map; nothing here is writable by the host
    always_comb begin
        case (cmd_r)
            CMD_BAT_CURRENT: rd_word = battery_current_result_r;
            CMD_INPUT_CURRENT: rd_word = input_current_cmp_result_r;
            CMD_RAIL_VOLTAGE: rd_word = rail_voltage_result_r;
            CMD_MAKER_CODE: rd_word = MAKER_CODE;
            CMD_PART_CODE: rd_word = {8'h00, PART_CODE};
            default: rd_word = UNMAPPED_VAL;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // serial engine: read word and write word, writes are acked and dropped
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            bitcnt_r <= BIT_NONE;
            shift_r <= 8'h00;
            cmd_r <= 8'h00;
            tx_r <= 16'h0000;
            rw_r <= 1'b0;
            byte_hi_r <= 1'b0;
            ack_ok_r <= 1'b0;
            sda_oe <= 1'b0;
        end else if (stop_cond) begin
            state_r <= ST_IDLE;
            sda_oe <= 1'b0;
        end else if (start_cond) begin
            // repeated start keeps the command byte
            state_r <= ST_ADDR;
            bitcnt_r <= BIT_NONE;
            sda_oe <= 1'b0;
        end else if (scl_rise) begin
            case (state_r)
                ST_ADDR, ST_CMD, ST_WDATA: begin
                    shift_r <= {shift_r[6:0], sda_s};
                    bitcnt_r <= bitcnt_r + 4'h1;
                end
                ST_RACK: ack_ok_r <= !sda_s;
                default: ;
            endcase
        end else if (scl_fall) begin
            case (state_r)
                ST_ADDR: begin
                    if (bitcnt_r == BITS_PER_BYTE) begin
                        if (shift_r[7:1] == SLAVE_ADDR) begin
                            state_r <= ST_ADDR_ACK;
                            rw_r <= shift_r[0];
                            sda_oe <= 1'b1;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    byte_hi_r <= 1'b0;
                    if (rw_r) begin
                        // whole word captured now, so both bytes are one round
                        state_r <= ST_RDATA;
                        sda_oe <= !rd_word[7];
                        tx_r <= {rd_word[6:0], rd_word[15:8], 1'b0};
                        bitcnt_r <= BIT_FIRST;
                    end else begin
                        state_r <= ST_CMD;
                        sda_oe <= 1'b0;
                        bitcnt_r <= BIT_NONE;
                    end
                end
                ST_CMD: begin
                    if (bitcnt_r == BITS_PER_BYTE) begin
                        state_r <= ST_CMD_ACK;
                        cmd_r <= shift_r;
                        sda_oe <= 1'b1;
                    end
                end
                ST_CMD_ACK, ST_WACK: begin
                    state_r <= ST_WDATA;
                    sda_oe <= 1'b0;
                    bitcnt_r <= BIT_NONE;
                end
                ST_WDATA: begin
                    // data bytes of a write are acked and discarded
                    if (bitcnt_r == BITS_PER_BYTE) begin
                        state_r <= ST_WACK;
                        sda_oe <= 1'b1;
                    end
                end
                ST_RDATA: begin
                    if (bitcnt_r == BITS_PER_BYTE) begin
                        state_r <= ST_RACK;
                        sda_oe <= 1'b0;
                    end else begin
                        sda_oe <= !tx_r[15];
                        tx_r <= {tx_r[14:0], 1'b0};
                        bitcnt_r <= bitcnt_r + 4'h1;
                    end
                end
                ST_RACK: begin
                    if (ack_ok_r && !byte_hi_r) begin
                        state_r <= ST_RDATA;
                        byte_hi_r <= 1'b1;
                        sda_oe <= !tx_r[15];
                        tx_r <= {tx_r[14:0], 1'b0};
                        bitcnt_r <= BIT_FIRST;
                    end else begin
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // open drain: only ever pulls low
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    wire logic snap_rd = scl_fall && state_r == ST_ADDR_ACK && rw_r;
    property p_chg;
        @(posedge sys_clk) disable iff (!reset_n)
        conv_done |=> battery_current_result_r[14:8] == $past(charge_current_reading);
    endproperty
    a_chg: assert property (p_chg) else $error("charge field not latched");

    property p_dchg;
        @(posedge sys_clk) disable iff (!reset_n)
        conv_done |=> battery_current_result_r[6:0] == $past(discharge_current_reading);
    endproperty
    a_dchg: assert property (p_dchg) else $error("discharge field not latched");

    property p_unused;
        @(posedge sys_clk) disable iff (!reset_n)
        !battery_current_result_r[15] && !battery_current_result_r[7];
    endproperty
    a_unused: assert property (p_unused) else $error("unused bits not zero");

    property p_iin_cmp;
        @(posedge sys_clk) disable iff (!reset_n)
        conv_done |=> input_current_cmp_result_r ==
            {$past(input_current_reading), $past(comparator_pin_level)};
    endproperty
    a_iin_cmp: assert property (p_iin_cmp) else $error("input word wrong");

    property p_sys;
        @(posedge sys_clk) disable iff (!reset_n)
        conv_done |=> rail_voltage_result_r[15:8] == $past(system_rail_reading);
    endproperty
    a_sys: assert property (p_sys) else $error("rail field wrong");

    property p_bat;
        @(posedge sys_clk) disable iff (!reset_n)
        conv_done |=> rail_voltage_result_r[7:0] == $past(battery_voltage_reading);
    endproperty
    a_bat: assert property (p_bat) else $error("battery voltage field wrong");

    property p_map;
        @(posedge sys_clk) disable iff (!reset_n)
        snap_rd && cmd_r == CMD_INPUT_CURRENT |=>
            tx_r[8:1] == $past(input_current_cmp_result_r[15:8]);
    endproperty
    a_map: assert property (p_map) else $error("command 25h maps wrong");

    property p_maker;
        @(posedge sys_clk) disable iff (!reset_n)
        snap_rd && cmd_r == CMD_MAKER_CODE |=>
            tx_r[8:1] == MAKER_CODE[15:8] && tx_r[15:9] == MAKER_CODE[6:0];
    endproperty
    a_maker: assert property (p_maker) else $error("maker code wrong");

    property p_part;
        @(posedge sys_clk) disable iff (!reset_n)
        snap_rd && cmd_r == CMD_PART_CODE |=> tx_r[8:1] == 8'h00 && tx_r[15:9] == PART_CODE[6:0];
    endproperty
    a_part: assert property (p_part) else $error("part code word wrong");

    property p_hold;
        @(posedge sys_clk) disable iff (!reset_n)
        !conv_done ##1 !conv_done |-> $stable(battery_current_result_r)
            && $stable(rail_voltage_result_r) && $stable(input_current_cmp_result_r);
    endproperty
    a_hold: assert property (p_hold) else $error("result changed without round");
endmodule : adcrd_readout
`default_nettype wire

// >>> adcrd_host_model.sv
// smbus host model that reads and writes words of the readout block
`default_nettype none
module adcrd_host_model (
    // clock the host paces its bus timing on
    input wire logic sys_clk,
    // open-drain bus: host drive and resolved line
    output var logic scl,
    output var logic sda_drv,
    input wire logic sda_line
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////
    // released lines rest high on the pull-up
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    // quarter bit of 4 cycles keeps scl low well past the setup need
    task automatic hold();
        repeat (4) @(negedge sys_clk);
    endtask : hold

    task automatic bit_io(input logic b, output logic r);
        sda_drv = b;
        hold();
        scl = 1'b1;
        hold();
        r = sda_line;
        hold();
        scl = 1'b0;
        hold();
    endtask : bit_io

    task automatic start_bit(input logic rep);
        if (rep) begin
            sda_drv = 1'b1;
            hold();
            scl = 1'b1;
            hold();
        end
        sda_drv = 1'b0;
        hold();
        scl = 1'b0;
        hold();
    endtask : start_bit

    task automatic stop_bit();
        sda_drv = 1'b0;
        hold();
        scl = 1'b1;
        hold();
        sda_drv = 1'b1;
        hold();
    endtask : stop_bit

    task automatic byte_out(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask : byte_out

    // last byte answered with nack to end the read
    task automatic byte_in(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(last, r);
    endtask : byte_in

    task automatic read_word(input logic [6:0] a, input logic [7:0] cmd,
                             output logic [15:0] d, output logic ok);
        logic k0;
        logic k1;
        logic k2;
        start_bit(1'b0);
        byte_out({a, 1'b0}, k0);
        byte_out(cmd, k1);
        start_bit(1'b1);
        byte_out({a, 1'b1}, k2);
        byte_in(1'b0, d[7:0]);
        byte_in(1'b1, d[15:8]);
        stop_bit();
        ok = k0 & k1 & k2;
    endtask : read_word

    task automatic write_word(input logic [6:0] a, input logic [7:0] cmd,
                              input logic [15:0] d, output logic ok);
        logic k0;
        logic k1;
        logic k2;
        logic k3;
        start_bit(1'b0);
        byte_out({a, 1'b0}, k0);
        byte_out(cmd, k1);
        byte_out(d[7:0], k2);
        byte_out(d[15:8], k3);
        stop_bit();
        ok = k0 & k1 & k2 & k3;
    endtask : write_word
endmodule : adcrd_host_model
`default_nettype wire

// >>> test_adcrd_readout.sv
// self-checking bench for the converter result and identification readout
`default_nettype none
module test_adcrd_readout import adcrd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [6:0] DEV_ADDR = 7'h09;
    localparam logic [15:0] TB_MAKER = 16'hc3d2; // arbitrary value
    localparam logic [7:0] TB_PART = 8'h6e; // arbitrary value
    logic sys_clk = 1'b0;
    logic reset_n;
    logic scl;
    logic sda_drv;
    logic sda_out;
    logic sda_oe;
    logic sda_line;
    logic conv_done;
    logic [45:0] rd_in;
    logic [45:0] cur;
    logic [45:0] vals [3];
    logic [7:0] cmds [5];
    logic [15:0] word;
    logic ok;
    int fail_count;
    int cmp_count;

    ////////////////////////////////////////
    always #12.5 sys_clk = ~sys_clk;
    assign sda_line = sda_drv & (sda_oe ? sda_out : 1'b1);

    adcrd_readout #(.SLAVE_ADDR(DEV_ADDR), .MAKER_CODE(TB_MAKER), .PART_CODE(TB_PART)) dut (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .scl_in(scl),
        .sda_in(sda_line),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .conv_done(conv_done),
        .charge_current_reading(rd_in[45:39]),
        .discharge_current_reading(rd_in[38:32]),
        .input_current_reading(rd_in[31:24]),
        .comparator_pin_level(rd_in[23:16]),
        .system_rail_reading(rd_in[15:8]),
        .battery_voltage_reading(rd_in[7:0])
    );

    adcrd_host_model host (
        .sys_clk(sys_clk),
        .scl(scl),
        .sda_drv(sda_drv),
        .sda_line(sda_line)
    );

    ////////////////////////////////////////
    function automatic logic [15:0] expect_word(input logic [45:0] v, input logic [7:0] c);
        case (c)
            8'h24: return {1'b0, v[45:39], 1'b0, v[38:32]};
            8'h25: return v[31:16];
            8'h26: return v[15:0];
            8'hfe: return TB_MAKER;
            8'hff: return {8'h00, TB_PART};
            default: return 16'h0000;
        endcase
    endfunction : expect_word

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic rd_chk(input logic [7:0] c, input logic [45:0] v);
        logic [15:0] m;
        host.read_word(DEV_ADDR, c, word, ok);
        check({15'h0000, ok}, 16'h0001);
        m = (c == 8'h24) ? 16'h7f7f : 16'hffff;
        check(word & m, expect_word(v, c) & m);
    endtask : rd_chk

    task automatic load(input logic [45:0] v);
        @(negedge sys_clk);
        rd_in = v;
        conv_done = 1'b1;
        @(negedge sys_clk);
        conv_done = 1'b0;
    endtask : load

    task automatic test_done();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    // guard against a hung bus sequence
    initial begin
        repeat (100000) @(negedge sys_clk);
        fail_count++;
        test_done();
    end

    initial begin
        reset_n = 1'b0;
        conv_done = 1'b0;
        rd_in = '0;
        cur = '0;
        fail_count = 0;
        cmp_count = 0;
        vals[0] = {7'h7f, 7'h00, 8'hff, 8'h00, 8'hff, 8'h00};
        vals[1] = {7'h00, 7'h7f, 8'h00, 8'hff, 8'h00, 8'hff};
        vals[2] = {7'h55, 7'h2a, 8'h81, 8'h3c, 8'hc3, 8'h18};
        cmds = '{8'h24, 8'h25, 8'h26, 8'hfe, 8'hff};
        repeat (12) @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        for (int i = 0; i < 5; i++) begin
            rd_chk(cmds[i], cur);
        end
        for (int k = 0; k < 3; k++) begin
            load(vals[k]);
            cur = vals[k];
            for (int i = 0; i < 5; i++) begin
                rd_chk(cmds[i], cur);
            end
        end
        // readings move without a pulse: words must not follow
        rd_in = ~cur;
        rd_chk(8'h25, cur);
        // a round landing in the data phase must not tear the word
        fork
            rd_chk(8'h26, cur);
            begin
                repeat (500) @(negedge sys_clk);
                load(vals[0]);
            end
        join
        cur = vals[0];
        rd_chk(8'h26, cur);
        // full-scale input code; a host with 10 milliohm sense scales it to 12.75 A
        rd_chk(8'h25, cur);
        check({8'h00, word[15:8]}, 16'h00ff);
        host.write_word(DEV_ADDR, 8'h24, 16'hffff, ok);
        check({15'h0000, ok}, 16'h0001);
        rd_chk(8'h24, cur);
        rd_chk(8'h27, cur);
        // foreign address is left unanswered
        host.read_word(7'h0b, 8'h24, word, ok);
        check({15'h0000, ok}, 16'h0000);
        test_done();
    end
endmodule : test_adcrd_readout
`default_nettype wire
